/* File: hdl/dsls_pkg.sv */
// Constants, encodings and carrier types shared by the data-share lane swizzle block
//------------------------------------------------------------------
//------------------------------------------------------------------
package dsls_pkg;

  // Wavefront geometry
  localparam int LANES = 64;
  localparam int DW = 32;
  localparam int LIDX_W = 6;
  localparam int OFF_W = 16;
  localparam int FIELD_W = 5;
  localparam int SEL_W = 2;
  localparam int OP_DATA_W = 128;

  // Mode boundaries of the combined offset
  localparam logic [15:0] FFT_MIN = 16'he000;
  localparam logic [15:0] ROT_MIN = 16'hc000;

  // Offset field positions
  localparam int MASK_LSB = 0;
  localparam int ROT_AMT_LSB = 5;
  localparam int ROT_DIR_BIT = 10;
  localparam int AND_LSB = 0;
  localparam int OR_LSB = 5;
  localparam int XOR_LSB = 10;
  localparam int QUAD_MODE_BIT = 15;
  localparam int HALF_BIT = 5;

  // Second address forming
  localparam int B_SEL_BIT = 7;
  localparam int A_EXT_LSB = 17;
  localparam int DWORD_SHIFT = 2;

  // Opcodes
  localparam logic [7:0] OPC_SYNC_RELEASE_ALL = 8'h98;
  localparam logic [7:0] OPC_SYNC_INIT = 8'h99;
  localparam logic [7:0] OPC_SYNC_SIGNAL = 8'h9a;
  localparam logic [7:0] OPC_SYNC_BULK_RELEASE = 8'h9b;
  localparam logic [7:0] OPC_TWO_SOURCE_UMIN64 = 8'hc7;
  localparam logic [7:0] OPC_TWO_SOURCE_UMAX64 = 8'hc8;
  localparam logic [7:0] OPC_WRITE_THREE_DWORDS = 8'hde;
  localparam logic [7:0] OPC_WRITE_FOUR_DWORDS = 8'hdf;

  // Memory write slots: software slot plus four operation slots
  localparam int WR_SLOTS = 5;
  localparam int SW_SLOT = 0;

  // Dwords moved by the wide writes
  localparam int W3_DWORDS = 3;
  localparam int W4_DWORDS = 4;

  // Issued instruction
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] offset_high_byte;
    logic [7:0] offset_low_byte;
    logic [31:0] addr;
    logic global_mem;
  } dsls_req_t;

  // Decoded operation class
  typedef enum logic [2:0] {
    OPK_NONE,
    OPK_LANE_PERMUTE,
    OPK_WRITE3,
    OPK_WRITE4,
    OPK_UMIN64,
    OPK_UMAX64,
    OPK_SYNC
  } dsls_opk_t;

endpackage

/* File: hdl/dsls_src_calc.sv */
// Source lane index for one destination lane of the swizzle network
`timescale 1ns/10ps
module dsls_src_calc
(
  // Control and lane
  input wire logic [15:0] offset_i,
  input wire logic [5:0] lane_i,
  // Chosen source lane
  output logic [5:0] src_o
);

  logic [4:0] low;
  logic [4:0] mask;
  logic [4:0] rev;
  logic [2:0] ones;
  logic [4:0] fft_j;
  logic [4:0] rot_amt;
  logic [4:0] rot_sum;
  logic [4:0] rot_j;
  logic [1:0] quad_sel;
  logic [4:0] x32_j;
  logic is_fft;
  logic is_rot;
  logic is_quad;

  // Shared fields
  assign low = lane_i[4:0];
  assign mask = offset_i[dsls_pkg::MASK_LSB +: dsls_pkg::FIELD_W];

  assign rev = {low[0], low[1], low[2], low[3], low[4]};
  assign ones = {2'h0, mask[0]} + {2'h0, mask[1]} + {2'h0, mask[2]} + {2'h0, mask[3]}
              + {2'h0, mask[4]};
  assign fft_j = (rev >> ones) | (low & mask);

  // rotate amount and direction; negation wraps within the 32-lane half
  assign rot_amt = offset_i[dsls_pkg::ROT_DIR_BIT]
                 ? 5'(-offset_i[dsls_pkg::ROT_AMT_LSB +: dsls_pkg::FIELD_W])
                 : offset_i[dsls_pkg::ROT_AMT_LSB +: dsls_pkg::FIELD_W];
  assign rot_sum = low + rot_amt;
  assign rot_j = (low & mask) | (rot_sum & ~mask);

  assign quad_sel = offset_i[{lane_i[1:0], 1'b0} +: dsls_pkg::SEL_W];

  assign x32_j = ((low & offset_i[dsls_pkg::AND_LSB +: dsls_pkg::FIELD_W])
               | offset_i[dsls_pkg::OR_LSB +: dsls_pkg::FIELD_W])
               ^ offset_i[dsls_pkg::XOR_LSB +: dsls_pkg::FIELD_W];

  assign is_fft = offset_i >= dsls_pkg::FFT_MIN;
  assign is_rot = !is_fft && (offset_i >= dsls_pkg::ROT_MIN);
  assign is_quad = offset_i[dsls_pkg::QUAD_MODE_BIT];

  // Bit 5 always comes from the own lane, keeping each half independent
  assign src_o = is_fft ? {lane_i[dsls_pkg::HALF_BIT], fft_j}
               : is_rot ? {lane_i[dsls_pkg::HALF_BIT], rot_j}
               : is_quad ? {lane_i[5:2], quad_sel}
               : {lane_i[dsls_pkg::HALF_BIT], x32_j};

endmodule

/* File: hdl/dsls_addr_calc.sv */
// Second address of a two-source operation
`timescale 1ns/10ps
module dsls_addr_calc
(
  // Base and offset bytes
  input wire logic [31:0] addr_a_i,
  input wire logic [7:0] offset_low_byte_i,
  input wire logic [7:0] offset_high_byte_i,
  // Second address
  output logic [31:0] addr_b_o
);

  logic [31:0] dw_off;

  // offset taken from the base itself or from the offset bytes
  assign dw_off = offset_high_byte_i[dsls_pkg::B_SEL_BIT]
                ? {{17{addr_a_i[31]}}, addr_a_i[31:dsls_pkg::A_EXT_LSB]}
                : {{17{offset_high_byte_i[6]}}, offset_high_byte_i[6:0], offset_low_byte_i};
  // scale to bytes, wrap at 32 bits
  assign addr_b_o = addr_a_i + {dw_off[29:0], 2'h0};

endmodule

/* File: hdl/dsls_top.sv */
// Data-share unit: lane swizzle network, share memory writes, two-source min/max, sync gate
`timescale 1ns/10ps
module dsls_top
#(
  parameter int MEM_AW = 8,
  parameter logic [7:0] OPC_LANE_PERMUTE = 8'hf0
)
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Instruction issue
  input wire logic req_valid_i,
  input wire dsls_pkg::dsls_req_t req_i,
  input wire logic [dsls_pkg::LANES*dsls_pkg::DW-1:0] lane_data_i,
  input wire logic [dsls_pkg::LANES-1:0] lane_valid_i,
  input wire logic [dsls_pkg::OP_DATA_W-1:0] op_data_i,
  // Lane permute result
  output logic res_valid_o,
  output logic [dsls_pkg::LANES*dsls_pkg::DW-1:0] res_data_o,
  output logic [dsls_pkg::LANES-1:0] res_mask_o,
  // Memory and sync completion
  output logic mem_done_o,
  output logic sync_done_o,
  output logic sync_refused_o,
  // Software port into share memory
  input wire logic [MEM_AW-1:0] sw_addr_i,
  input wire logic [31:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [31:0] sw_rdata_o
);

  //------------------------------------------------------------------
  // Storage and internal signals
  //------------------------------------------------------------------
  localparam int MEM_WORDS = 1 << MEM_AW;
  localparam int LW = dsls_pkg::LANES * dsls_pkg::DW;

  // Share memory, one dword per entry
  logic [31:0] mem_q [MEM_WORDS];

  logic [15:0] offset;
  dsls_pkg::dsls_opk_t opk;
  logic is_sync_opc;
  logic [31:0] addr_b;
  logic [MEM_AW-1:0] idx_a;
  logic [MEM_AW-1:0] idx_b;
  logic [63:0] qword_a;
  logic [63:0] qword_b;
  logic a_lt_b;
  logic [63:0] minmax;
  logic [LW-1:0] perm_data;
  logic wr_en [dsls_pkg::WR_SLOTS];
  logic [MEM_AW-1:0] wr_idx [dsls_pkg::WR_SLOTS];
  logic [31:0] wr_dat [dsls_pkg::WR_SLOTS];
  logic res_valid_d;
  logic res_valid_q;
  logic [LW-1:0] res_data_q;
  logic [dsls_pkg::LANES-1:0] res_mask_q;
  logic mem_done_d;
  logic mem_done_q;
  logic sync_done_d;
  logic sync_done_q;
  logic sync_refused_d;
  logic sync_refused_q;
  logic [31:0] sw_rdata_q;
  // Opcode hits, one per single-opcode operation class
  logic hit_perm;
  logic hit_write3;
  logic hit_write4;
  logic hit_umin;
  logic hit_umax;

  //------------------------------------------------------------------
  // Instruction decode
  //------------------------------------------------------------------
  // combined swizzle control
  assign offset = {req_i.offset_high_byte, req_i.offset_low_byte};

  // Opcode classification; unknown opcodes are ignored
  assign is_sync_opc = (req_i.opcode == dsls_pkg::OPC_SYNC_RELEASE_ALL)
                    || (req_i.opcode == dsls_pkg::OPC_SYNC_INIT)
                    || (req_i.opcode == dsls_pkg::OPC_SYNC_SIGNAL)
                    || (req_i.opcode == dsls_pkg::OPC_SYNC_BULK_RELEASE);

  // Named hits keep the class selection below a plain priority chain
  assign hit_perm = req_i.opcode == OPC_LANE_PERMUTE;
  assign hit_write3 = req_i.opcode == dsls_pkg::OPC_WRITE_THREE_DWORDS;
  assign hit_write4 = req_i.opcode == dsls_pkg::OPC_WRITE_FOUR_DWORDS;
  assign hit_umin = req_i.opcode == dsls_pkg::OPC_TWO_SOURCE_UMIN64;
  assign hit_umax = req_i.opcode == dsls_pkg::OPC_TWO_SOURCE_UMAX64;

  // One class per issue; nothing happens without the valid strobe
  always_comb
  begin
    opk = dsls_pkg::OPK_NONE;
    if (req_valid_i)
    begin
      if (hit_perm)
      begin
        opk = dsls_pkg::OPK_LANE_PERMUTE;
      end
      else if (hit_write3)
      begin
        opk = dsls_pkg::OPK_WRITE3;
      end
      else if (hit_write4)
      begin
        opk = dsls_pkg::OPK_WRITE4;
      end
      else if (hit_umin)
      begin
        opk = dsls_pkg::OPK_UMIN64;
      end
      else if (hit_umax)
      begin
        opk = dsls_pkg::OPK_UMAX64;
      end
      else if (is_sync_opc)
      begin
        opk = dsls_pkg::OPK_SYNC;
      end
    end
  end

  //------------------------------------------------------------------
  // Swizzle network
  //------------------------------------------------------------------
  // The index units share one control word, so a new offset reaches every lane at once
  // Per-lane source selection across the whole wavefront
  // one source index per lane
  for (genvar i = 0; i < dsls_pkg::LANES; i++)
  begin : g_lane
    logic [5:0] src;
    logic [31:0] src_word;

    dsls_src_calc u_src
    (
      .offset_i(offset),
      .lane_i(6'(i)),
      .src_o(src)
    );

    // Gating on both ends means stale data of an idle lane never leaks out
    // inactive source reads as zero
    assign src_word = lane_valid_i[src] ? lane_data_i[src*dsls_pkg::DW +: dsls_pkg::DW] : 32'h0;
    // only active destination lanes carry a result
    assign perm_data[i*dsls_pkg::DW +: dsls_pkg::DW] = lane_valid_i[i] ? src_word : 32'h0;
  end

  //------------------------------------------------------------------
  // Two-source min/max
  //------------------------------------------------------------------
  // Both operands come from this array, so the whole update ends in the issue cycle
  // Second address for two-source operations
  dsls_addr_calc u_addr
  (
    .addr_a_i(req_i.addr),
    .offset_low_byte_i(req_i.offset_low_byte),
    .offset_high_byte_i(req_i.offset_high_byte),
    .addr_b_o(addr_b)
  );

  // High address bits are dropped on purpose: the array is smaller than the address space
  // Dword indices; addresses wrap within the memory
  assign idx_a = req_i.addr[dsls_pkg::DWORD_SHIFT +: MEM_AW];
  assign idx_b = addr_b[dsls_pkg::DWORD_SHIFT +: MEM_AW];

  // If B overlaps A the compare sees the old words, never a half-written value
  // Both qwords are read in the cycle of issue, so the update is atomic
  assign qword_a = {mem_q[MEM_AW'(idx_a + MEM_AW'(1))], mem_q[idx_a]};
  assign qword_b = {mem_q[MEM_AW'(idx_b + MEM_AW'(1))], mem_q[idx_b]};
  assign a_lt_b = qword_a < qword_b;
  // unsigned min or max of the two qwords
  assign minmax = (opk == dsls_pkg::OPK_UMIN64) ? (a_lt_b ? qword_a : qword_b)
                                                : (a_lt_b ? qword_b : qword_a);

  //------------------------------------------------------------------
  // Share memory writes
  //------------------------------------------------------------------
  // A software write to a dword that an operation writes in the same cycle is lost;
  // software must not count on such a write landing
  // Write slot assignment; operation slots follow the software slot and win on a clash
  always_comb
  begin
    for (int k = 0; k < dsls_pkg::WR_SLOTS; k++)
    begin
      wr_en[k] = 1'b0;
      wr_idx[k] = idx_a;
      wr_dat[k] = 32'h0;
    end
    wr_en[dsls_pkg::SW_SLOT] = sw_wr_i;
    wr_idx[dsls_pkg::SW_SLOT] = sw_addr_i;
    wr_dat[dsls_pkg::SW_SLOT] = sw_wdata_i;
    case (opk)
      // three dwords, low dword at the base
      dsls_pkg::OPK_WRITE3:
      begin
        for (int k = 1; k <= dsls_pkg::W3_DWORDS; k++)
        begin
          wr_en[k] = 1'b1;
          wr_idx[k] = MEM_AW'(idx_a + MEM_AW'(k - 1));
          wr_dat[k] = op_data_i[(k-1)*dsls_pkg::DW +: dsls_pkg::DW];
        end
      end
      // four dwords, low dword at the base
      dsls_pkg::OPK_WRITE4:
      begin
        for (int k = 1; k <= dsls_pkg::W4_DWORDS; k++)
        begin
          wr_en[k] = 1'b1;
          wr_idx[k] = MEM_AW'(idx_a + MEM_AW'(k - 1));
          wr_dat[k] = op_data_i[(k-1)*dsls_pkg::DW +: dsls_pkg::DW];
        end
      end
      // result replaces the qword at the base
      dsls_pkg::OPK_UMIN64, dsls_pkg::OPK_UMAX64:
      begin
        wr_en[1] = 1'b1;
        wr_idx[1] = idx_a;
        wr_dat[1] = minmax[31:0];
        wr_en[2] = 1'b1;
        wr_idx[2] = MEM_AW'(idx_a + MEM_AW'(1));
        wr_dat[2] = minmax[63:32];
      end
      // a lane permute owns no write slot
      dsls_pkg::OPK_LANE_PERMUTE:
      begin
        wr_en[1] = 1'b0;
      end
      // Unknown opcodes and sync operations leave the memory untouched
      default:
      begin
        wr_en[1] = 1'b0;
      end
    endcase
  end

  // No reset here: contents are undefined until written, which keeps it plain storage
  // Share memory update; later slots take priority
  always_ff @(posedge sys_clk_i)
  begin
    for (int k = 0; k < dsls_pkg::WR_SLOTS; k++)
    begin
      if (wr_en[k])
      begin
        mem_q[wr_idx[k]] <= wr_dat[k];
      end
    end
  end

  //------------------------------------------------------------------
  // Completion and status
  //------------------------------------------------------------------
  // Completion decode
  assign res_valid_d = opk == dsls_pkg::OPK_LANE_PERMUTE;
  assign mem_done_d = (opk == dsls_pkg::OPK_WRITE3) || (opk == dsls_pkg::OPK_WRITE4)
                   || (opk == dsls_pkg::OPK_UMIN64) || (opk == dsls_pkg::OPK_UMAX64);
  // A refused sync op still answers, so the core never waits on local memory
  // sync operations only in the global share memory
  assign sync_done_d = (opk == dsls_pkg::OPK_SYNC) && req_i.global_mem;
  assign sync_refused_d = (opk == dsls_pkg::OPK_SYNC) && !req_i.global_mem;

  //------------------------------------------------------------------
  // Status pulses
  //------------------------------------------------------------------
  // Pulses last one cycle; a held pulse would count as a second completion
  // Status pulses, one cycle after issue
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      res_valid_q <= 1'b0;
      mem_done_q <= 1'b0;
      sync_done_q <= 1'b0;
      sync_refused_q <= 1'b0;
    end
    else
    begin
      res_valid_q <= res_valid_d;
      mem_done_q <= mem_done_d;
      sync_done_q <= sync_done_d;
      sync_refused_q <= sync_refused_d;
    end
  end

  //------------------------------------------------------------------
  // Permute result
  //------------------------------------------------------------------
  // Held between permutes so the core may pick the result up late
  // Permute result holds until the next permute
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      res_data_q <= '0;
      res_mask_q <= '0;
    end
    else if (res_valid_d)
    begin
      res_data_q <= perm_data;
      res_mask_q <= lane_valid_i;
    end
  end

  //------------------------------------------------------------------
  // Software port
  //------------------------------------------------------------------
  // The read path is a single flop, so the master never waits
  // Zero outside the answer cycle keeps a stale word from looking like a fresh read
  // Software read: data stands in the cycle after the strobe only
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      sw_rdata_q <= 32'h0;
    end
    else if (sw_rd_i)
    begin
      sw_rdata_q <= mem_q[sw_addr_i];
    end
    else
    begin
      sw_rdata_q <= 32'h0;
    end
  end

  //------------------------------------------------------------------
  // Output drivers
  //------------------------------------------------------------------
  // No logic on the way out, so pin timing is that of the flops alone
  // Outputs straight from flip-flops
  assign res_valid_o = res_valid_q;
  assign res_data_o = res_data_q;
  assign res_mask_o = res_mask_q;
  assign mem_done_o = mem_done_q;
  assign sync_done_o = sync_done_q;
  assign sync_refused_o = sync_refused_q;
  assign sw_rdata_o = sw_rdata_q;

endmodule

/* File: verif/dsls_monitor.sv */
// Checker of the issue, result and completion ports of the data-share block
`timescale 1ns/10ps
module dsls_monitor
#(
  parameter logic [7:0] OPC_LANE_PERMUTE = 8'hf0
)
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Issue side
  input wire logic req_valid_i,
  input wire dsls_pkg::dsls_req_t req_i,
  input wire logic [dsls_pkg::LANES-1:0] lane_valid_i,
  // Results and completions
  input wire logic res_valid_o,
  input wire logic [dsls_pkg::LANES*dsls_pkg::DW-1:0] res_data_o,
  input wire logic [dsls_pkg::LANES-1:0] res_mask_o,
  input wire logic mem_done_o,
  input wire logic sync_done_o,
  input wire logic sync_refused_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // Request classes, decoded here so a wrong opcode decode shows up
  wire logic op_perm = req_valid_i && req_i.opcode == OPC_LANE_PERMUTE;
  wire logic op_sync = req_valid_i && req_i.opcode[7:2] == dsls_pkg::OPC_SYNC_INIT[7:2];
  wire logic op_mem = req_valid_i && req_i.opcode inside {dsls_pkg::OPC_TWO_SOURCE_UMIN64,
    dsls_pkg::OPC_TWO_SOURCE_UMAX64, dsls_pkg::OPC_WRITE_THREE_DWORDS,
    dsls_pkg::OPC_WRITE_FOUR_DWORDS};

  // Lanes outside the returned mask must read as zero
  logic [dsls_pkg::LANES*dsls_pkg::DW-1:0] off_lanes;
  always_comb
    for (int k = 0; k < dsls_pkg::LANES; k++)
      off_lanes[k*32+:32] = {32{!res_mask_o[k]}};

  sequence s_perm;
    op_perm;
  endsequence
  sequence s_mem;
    op_mem;
  endsequence

  a_perm_answer: assert property (s_perm |=> res_valid_o && res_mask_o == $past(lane_valid_i))
    else $error("permute result or mask missing");
  a_perm_cause: assert property (res_valid_o |-> $past(op_perm))
    else $error("permute result without permute issue");
  a_perm_no_mem: assert property (s_perm |=> !mem_done_o && !sync_done_o)
    else $error("permute touched share memory");
  a_zero_inactive: assert property (res_valid_o |-> (res_data_o & off_lanes) == '0)
    else $error("inactive lane not zero");
  a_data_hold: assert property (!op_perm |=> $stable(res_data_o))
    else $error("permute data changed without issue");
  a_mem_done: assert property (s_mem |=> mem_done_o)
    else $error("memory op not completed");
  a_mem_cause: assert property (mem_done_o |-> $past(op_mem))
    else $error("memory completion without op");
  a_sync_done: assert property (op_sync && req_i.global_mem |=> sync_done_o && !sync_refused_o)
    else $error("global sync op not done");
  a_sync_refuse: assert property (op_sync && !req_i.global_mem |=> sync_refused_o && !sync_done_o)
    else $error("local sync op not refused");
endmodule

/* File: verif/dsls_core_model.sv */
// Behavioural issuing core that drives data-share instructions
`timescale 1ns/10ps
module dsls_core_model
(
  // Clock
  input wire logic sys_clk_i,
  // Issue port
  output logic req_valid_o,
  output dsls_pkg::dsls_req_t req_o,
  output logic [2047:0] lane_data_o,
  output logic [63:0] lane_valid_o,
  output logic [127:0] op_data_o
);
  logic [2047:0] last_q = '0;
  logic [7:0] seq_q = 8'h0;

  // Quiet issue port at time zero
  initial
  begin
    req_valid_o = 1'b0;
    req_o = '0;
    lane_data_o = '0;
    lane_valid_o = '0;
    op_data_o = '0;
  end

  // One issue cycle; released lines are inverted so stale values never match
  task automatic issue(input logic [7:0] opc, input logic [15:0] off, input logic [31:0] a,
    input logic g, input logic [63:0] lv, input logic [127:0] od);
    for (int k = 0; k < 64; k++)
      last_q[k*32+:32] = {8'ha5, seq_q, 10'h0, 6'(k)};
    seq_q++;
    req_o <= '{opc, off[15:8], off[7:0], a, g};
    lane_data_o <= last_q;
    lane_valid_o <= lv;
    op_data_o <= od;
    req_valid_o <= 1'b1;
    @(posedge sys_clk_i);
    req_valid_o <= 1'b0;
    req_o <= ~req_o;
    lane_data_o <= ~last_q;
    lane_valid_o <= ~lv;
    op_data_o <= ~od;
    #1;
  endtask
endmodule

/* File: verif/testbench.sv */
// Self-checking bench for the data-share lane swizzle block
`timescale 1ns/10ps
module testbench;
  localparam logic [7:0] PERM = 8'hf0;
  localparam logic [63:0] LV = 64'hfffe_ffff_7fff_fff6;
  localparam logic [127:0] OD = 128'hdddd0004_cccc0003_bbbb0002_aaaa0001;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic req_valid_i;
  dsls_pkg::dsls_req_t req_i;
  logic [2047:0] lane_data_i;
  logic [63:0] lane_valid_i;
  logic [127:0] op_data_i;
  logic res_valid_o;
  logic mem_done_o;
  logic sync_done_o;
  logic sync_refused_o;
  logic [2047:0] res_data_o;
  logic [63:0] res_mask_o;
  logic [7:0] sw_addr_i = 8'h0;
  logic [31:0] sw_wdata_i = 32'h0;
  logic sw_wr_i = 1'b0;
  logic sw_rd_i = 1'b0;
  logic [31:0] sw_rdata_o;
  int err_count = 0;
  int comparisons = 0;
  // Mode table: FFT, rotate, quad, 32-lane, with boundaries
  logic [15:0] offs [12] = '{16'he000, 16'he010, 16'he01f, 16'hc020, 16'hc420, 16'hc021,
    16'hc421, 16'hdfff, 16'h801b, 16'hbfff, 16'h7c1f, 16'h0060};

  always #20 sys_clk_i = ~sys_clk_i;

  dsls_core_model core (.sys_clk_i(sys_clk_i), .req_valid_o(req_valid_i), .req_o(req_i),
    .lane_data_o(lane_data_i), .lane_valid_o(lane_valid_i), .op_data_o(op_data_i));

  dsls_top #(.MEM_AW(8), .OPC_LANE_PERMUTE(PERM)) uut (.sys_clk_i, .sys_rst_i, .req_valid_i,
    .req_i, .lane_data_i, .lane_valid_i, .op_data_i, .res_valid_o, .res_data_o, .res_mask_o,
    .mem_done_o, .sync_done_o, .sync_refused_o, .sw_addr_i, .sw_wdata_i, .sw_wr_i, .sw_rd_i,
    .sw_rdata_o);

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Strobes drop by NBA at the taking edge, so back-to-back calls never clash
  task automatic sw_write(input logic [7:0] a, input logic [31:0] d);
    sw_addr_i <= a;
    sw_wdata_i <= d;
    sw_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    sw_wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    sw_addr_i <= a;
    sw_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    sw_rd_i <= 1'b0;
    #1;
    chk(sw_rdata_o, e);
  endtask

  // Expected source lane, written from the mode descriptions
  function automatic logic [5:0] ref_src(input logic [15:0] o, input logic [5:0] l);
    logic [4:0] r;
    logic [4:0] j;
    if (o >= 16'he000)
    begin
      for (int b = 0; b < 5; b++)
        r[b] = l[4-b];
      j = (r >> $countones(o[4:0])) | (l[4:0] & o[4:0]);
    end
    else if (o >= 16'hc000)
    begin
      r = o[10] ? 5'h0 - o[9:5] : o[9:5];
      j = (l[4:0] & o[4:0]) | ((l[4:0] + r) & ~o[4:0]);
    end
    else if (o[15])
      return {l[5:2], o[2*l[1:0]+:2]};
    else
      j = ((l[4:0] & o[4:0]) | o[9:5]) ^ o[14:10];
    return {l[5], j};
  endfunction

  // Seed both qwords, run the op, read back the base qword
  task automatic mm(input logic [7:0] o, input logic [15:0] f, input logic [31:0] a,
    input logic [7:0] ib, input logic [63:0] qa, qb, qe);
    sw_write(a[9:2], qa[31:0]);
    sw_write(a[9:2] + 8'h1, qa[63:32]);
    sw_write(ib, qb[31:0]);
    sw_write(ib + 8'h1, qb[63:32]);
    core.issue(o, f, a, 1'b0, LV, '0);
    chk(mem_done_o, 1'b1);
    rd_chk(a[9:2], qe[31:0]);
    rd_chk(a[9:2] + 8'h1, qe[63:32]);
  endtask

  task automatic results();
    $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Whole run is about 50 cycles; this limit is far beyond it
  initial
  begin
    #400000;
    err_count++;
    results();
  end

  initial
  begin
    logic [5:0] s;
    repeat (5) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    #1;
    sw_write(8'h14, 32'h0ddba11);
    foreach (offs[n])
    begin
      core.issue(PERM, offs[n], 32'h50, 1'b0, LV, '0);
      chk(res_mask_o, LV);
      chk(res_valid_o, 1'b1);
      chk(mem_done_o, 1'b0);
      for (int k = 0; k < 64; k++)
      begin
        s = ref_src(offs[n], 6'(k));
        chk(res_data_o[k*32+:32], (LV[k] && LV[s]) ? core.last_q[s*32+:32] : 32'h0);
      end
    end
    rd_chk(8'h14, 32'h0ddba11);
    $display("test permute end");
    sw_write(8'h13, 32'h0ddba11);
    core.issue(dsls_pkg::OPC_WRITE_THREE_DWORDS, 16'h0, 32'h40, 1'b0, LV, OD);
    chk(mem_done_o, 1'b1);
    for (int k = 0; k < 4; k++)
      rd_chk(8'h10 + 8'(k), k < 3 ? OD[k*32+:32] : 32'h0ddba11);
    core.issue(dsls_pkg::OPC_WRITE_FOUR_DWORDS, 16'h0, 32'h40, 1'b0, LV, ~OD);
    chk(mem_done_o, 1'b1);
    for (int k = 0; k < 4; k++)
      rd_chk(8'h10 + 8'(k), ~OD[k*32+:32]);
    $display("test wide writes end");
    mm(dsls_pkg::OPC_TWO_SOURCE_UMIN64, 16'h7ffe, 32'h108, 8'h40, 64'h1_00000000,
      64'h0_ffffffff, 64'h0_ffffffff);
    mm(dsls_pkg::OPC_TWO_SOURCE_UMAX64, 16'h8000, 32'h40010, 8'h06, 64'h5,
      64'h2_00000000, 64'h2_00000000);
    $display("test min max end");
    for (int k = 0; k < 8; k++)
    begin
      core.issue(dsls_pkg::OPC_SYNC_RELEASE_ALL + 8'(k >> 1), 16'h0, 32'h0, k[0], LV, '0);
      chk(sync_done_o, k[0]);
      chk(sync_refused_o, !k[0]);
    end
    $display("test sync end");
    results();
  end
endmodule

bind dsls_top dsls_monitor #(.OPC_LANE_PERMUTE(OPC_LANE_PERMUTE)) mon (.sys_clk_i, .sys_rst_i,
  .req_valid_i, .req_i, .lane_valid_i, .res_valid_o, .res_data_o, .res_mask_o, .mem_done_o,
  .sync_done_o, .sync_refused_o);
